// file: compressed_byte_ops_and_stack_frame.sv
/*
  Execute logic for the compressed byte/halfword store, extend, complement
  and multiply group, and for the frame push / pop / pop-return sequences.
  Assumes the core presents operands of x(8+rs1') and x(8+rs2') with the
  instruction, holds an instruction while busy, reads its register file
  combinationally, and keeps one memory access outstanding at a time.
*/
// Function
// RL1 - byte store writes low 8 bits of second source at base plus offset.
// RL2 - halfword store writes low 16 bits of second source at base plus offset.
// RL3 - halfword store offset: bit1 from instr bit5, all other bits zero.
// RL4 - every three-bit register field selects x8 to x15.
// RL5 - byte zero-extend keeps bits 7..0, clears the rest, writes back.
// RL6 - byte sign-extend copies bit 7 into all higher bits.
// RL7 - halfword zero-extend keeps bits 15..0, clears higher bits.
// RL8 - halfword sign-extend copies bit 15 into all higher bits.
// RL9 - word zero-extend keeps bits 31..0, clears higher bits.
// RL10 - complement replaces the register with its one's complement.
// RL11 - multiply writes low XLEN bits of signed product into first register.
// RL12 - multiply needs M or Zmmul; extends need Zbb; word extend needs Zba. Here byte zero-extend needs no Zbb, and word extend needs Zba only.
// RL13 - push lowers the stack pointer and stores every listed register.
// RL14 - pop loads every listed register, then raises the stack pointer.
// RL15 - zeroing pop-return also writes zero into a0.
// RL16 - pop-return jumps to return address after restore and release.
// RL17 - byte store offset: bit1 from instr bit5, bit0 from instr bit6.
// RL18 - frame adjustment adds encoded extra amount in 16-byte steps.
// RL19 - push commits the stack pointer only after all stores succeed.
module compressed_byte_ops_and_stack_frame (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // instruction issue and configuration
  input cbops_pkg::issue_t I_ISSUE,
  input cbops_pkg::cfg_t I_CFG,
  // register file read port
  output logic [4:0] O_RF_RADDR,
  input wire logic [63:0] I_RF_RDATA,
  // memory port
  output cbops_pkg::mem_req_t O_MEM,
  input wire logic I_MEM_READY,
  input cbops_pkg::mem_resp_t I_MEM_RESP,
  // results and status
  output cbops_pkg::wb_t O_WB,
  output cbops_pkg::jump_t O_JUMP,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_FAULT,
  output logic O_ILLEGAL
);
  import cbops_pkg::*;

  // compact register field to full register number
  function automatic logic [4:0] creg(input logic [2:0] f);
    creg = {CREG_HI, f}; // RL4
  endfunction

  // frame slot k: ra, s0, s1, then s2.. at x18 upward
  function automatic logic [4:0] slot_reg(input logic [3:0] k);
    case (k)
      4'h0: slot_reg = REG_RA;
      4'h1: slot_reg = REG_S0;
      4'h2: slot_reg = REG_S1;
      default: slot_reg = {1'b0, k} + SLOT_S2_BIAS;
    endcase
  endfunction

  // slot k sits (n-k) doublewords below the frame top
  function automatic logic [XLEN-1:0] slot_addr(input logic [XLEN-1:0] top,
                                                input logic [3:0] n,
                                                input logic [3:0] k);
    logic [3:0] d;
    d = n - k;
    slot_addr = top - XLEN'({d, 3'b000});
  endfunction

  // unary extend / complement result
  function automatic logic [XLEN-1:0] unary(input logic [2:0] op,
                                            input logic [XLEN-1:0] v);
    case (op)
      U_ZEXT_B: unary = {{(XLEN-8){1'b0}}, v[7:0]}; // RL5
      U_SEXT_B: unary = {{(XLEN-8){v[7]}}, v[7:0]}; // RL6
      U_ZEXT_H: unary = {{(XLEN-16){1'b0}}, v[15:0]}; // RL7
      U_SEXT_H: unary = {{(XLEN-16){v[15]}}, v[15:0]}; // RL8
      U_ZEXT_W: unary = {{(XLEN-32){1'b0}}, v[31:0]}; // RL9
      U_NOT: unary = v ^ {XLEN{1'b1}}; // RL10
      default: unary = v;
    endcase
  endfunction

  state_t state_q, state_d;
  frame_op_t op_q, op_dec;
  logic frame_q, busy_q, done_q, fault_q, illegal_q;
  logic [3:0] nslots_q, slot_q;
  logic [XLEN-1:0] top_q, sp_q, adj_q, ret_q;
  logic [4:0] raddr_q;
  mem_req_t mem_q;
  wb_t wb_q;
  jump_t jmp_q;

  // field decode of the offered instruction
  wire [15:0] ins = I_ISSUE.instr;
  wire idle = (state_q == ST_IDLE);
  wire take = idle && I_ISSUE.valid;
  wire [2:0] uop = ins[4:2];
  wire dec_sb = (ins[1:0] == OP_Q0) && (ins[15:10] == F6_STORE_B);
  wire dec_sh = (ins[1:0] == OP_Q0) && (ins[15:10] == F6_STORE_H) && !ins[6];
  wire dec_cu = (ins[1:0] == OP_Q1) && (ins[15:10] == F6_UNARY);
  wire dec_un = dec_cu && (ins[6:5] == SEL_UNARY);
  wire dec_mul = dec_cu && (ins[6:5] == SEL_MUL);
  wire [4:0] pp_sel = ins[12:8];
  wire dec_pp = (ins[1:0] == OP_Q2) && (ins[15:13] == F3_FRAME)
                && (pp_sel == PP_PUSH || pp_sel == PP_POP
                    || pp_sel == PP_POPRETZ || pp_sel == PP_POPRET);
  wire [3:0] rlist = ins[7:4];
  wire [1:0] spimm = ins[3:2];

  // extension gating: unsupported forms are refused as illegal
  wire un_ok = (uop == U_ZEXT_B) || (uop == U_NOT)
               || (I_CFG.has_zbb && (uop == U_SEXT_B || uop == U_ZEXT_H
                                     || uop == U_SEXT_H))
               || (I_CFG.has_zba && uop == U_ZEXT_W); // RL12
  wire mul_ok = I_CFG.has_m || I_CFG.has_zmmul; // RL12
  wire go_alu = take && ((dec_un && un_ok) || (dec_mul && mul_ok));
  wire go_store = take && (dec_sb || dec_sh);
  wire go_frame = take && dec_pp && (rlist >= RLIST_MIN);
  wire go_push = go_frame && (pp_sel == PP_PUSH);
  wire go_pop = go_frame && (pp_sel != PP_PUSH);
  assign op_dec = (pp_sel == PP_PUSH) ? FR_PUSH
                : (pp_sel == PP_POP) ? FR_POP
                : (pp_sel == PP_POPRET) ? FR_POPRET : FR_POPRETZ;

  // operation results
  wire [XLEN-1:0] mul_res = XLEN'($signed(I_ISSUE.rsd_val) * $signed(I_ISSUE.rs2_val)); // RL11
  wire [XLEN-1:0] alu_res = dec_mul ? mul_res : unary(uop, I_ISSUE.rsd_val);

  // store offsets zero-extended, base is the rs1' operand
  wire [XLEN-1:0] sb_off = XLEN'({ins[5], ins[6]}); // RL17
  wire [XLEN-1:0] sh_off = XLEN'({ins[5], 1'b0}); // RL3
  wire [XLEN-1:0] st_addr = I_ISSUE.rsd_val + (dec_sb ? sb_off : sh_off);
  wire [XLEN-1:0] st_data = dec_sb ? XLEN'(I_ISSUE.rs2_val[7:0]) // RL1
                                   : XLEN'(I_ISSUE.rs2_val[15:0]); // RL2

  // frame geometry: register pairs round up to 16 bytes, plus 16-byte steps
  wire [3:0] n_dec = (rlist == RLIST_ALL) ? NSLOT_ALL : rlist - RLIST_BIAS;
  wire [3:0] pairs = (n_dec + 4'h1) >> 1;
  wire [7:0] adj8 = {pairs + {2'b00, spimm}, 4'h0}; // RL18
  wire [XLEN-1:0] adj_dec = XLEN'(adj8);
  wire [XLEN-1:0] top_dec = go_push ? I_ISSUE.sp_val : I_ISSUE.sp_val + adj_dec;

  // sequencing terms
  wire is_push = (op_q == FR_PUSH);
  wire is_ret = (op_q == FR_POPRET) || (op_q == FR_POPRETZ);
  wire last_slot = (slot_q == nslots_q - 4'h1);
  wire [3:0] slot_nx = slot_q + 4'h1;
  wire resp_ok = (state_q == ST_RESP) && I_MEM_RESP.valid && !I_MEM_RESP.err;
  wire resp_err = (state_q == ST_RESP) && I_MEM_RESP.valid && I_MEM_RESP.err;

  // next state; a fault drops the sequence before any frame commit
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = (go_store || go_pop) ? ST_REQ : (go_push ? ST_RD : ST_IDLE);
      ST_RD: state_d = ST_REQ;
      ST_REQ: state_d = I_MEM_READY ? ST_RESP : ST_REQ;
      ST_RESP: begin
        if (resp_err) begin
          state_d = ST_IDLE; // RL19
        end else if (resp_ok) begin
          if (!frame_q) begin
            state_d = ST_IDLE;
          end else if (!last_slot) begin
            state_d = is_push ? ST_RD : ST_REQ; // RL13
          end else if (op_q == FR_POPRETZ) begin
            state_d = ST_A0;
          end else begin
            state_d = ST_SP;
          end
        end
      end
      ST_A0: state_d = ST_SP;
      ST_SP: state_d = is_ret ? ST_RET : ST_IDLE; // RL16
      ST_RET: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // state and busy flag
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // datapath; result strobes last one cycle
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      op_q <= FR_PUSH;
      frame_q <= 1'b0;
      nslots_q <= 4'h0;
      slot_q <= 4'h0;
      top_q <= '0;
      sp_q <= '0;
      adj_q <= '0;
      ret_q <= '0;
      raddr_q <= 5'h00;
      mem_q <= '0;
      wb_q <= '0;
      jmp_q <= '0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      wb_q.valid <= 1'b0;
      jmp_q.valid <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
      illegal_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (go_alu) begin
            wb_q <= '{1'b1, creg(ins[9:7]), alu_res}; // RL11
            done_q <= 1'b1;
          end else if (go_store) begin
            mem_q <= '{1'b1, 1'b1, dec_sb ? SZ_B : SZ_H, st_addr, st_data}; // RL1
            frame_q <= 1'b0;
          end else if (go_frame) begin
            op_q <= op_dec;
            frame_q <= 1'b1;
            nslots_q <= n_dec;
            slot_q <= 4'h0;
            sp_q <= I_ISSUE.sp_val;
            adj_q <= adj_dec;
            top_q <= top_dec;
            raddr_q <= REG_RA;
            if (go_pop) begin
              mem_q <= '{1'b1, 1'b0, SZ_D, slot_addr(top_dec, n_dec, 4'h0), '0}; // RL14
            end
          end else if (take) begin
            illegal_q <= 1'b1; // RL12
          end
        end
        ST_RD: mem_q <= '{1'b1, 1'b1, SZ_D, slot_addr(top_q, nslots_q, slot_q),
                          I_RF_RDATA}; // RL13
        ST_REQ: mem_q.valid <= !I_MEM_READY;
        ST_RESP: begin
          if (resp_err) begin
            fault_q <= 1'b1; // RL19
          end else if (resp_ok) begin
            done_q <= !frame_q;
            if (frame_q && !is_push) begin
              wb_q <= '{1'b1, slot_reg(slot_q), I_MEM_RESP.rdata}; // RL14
              if (slot_q == 4'h0) begin
                ret_q <= I_MEM_RESP.rdata;
              end
            end
            if (frame_q && !last_slot) begin
              slot_q <= slot_nx;
              raddr_q <= slot_reg(slot_nx);
              if (!is_push) begin
                mem_q <= '{1'b1, 1'b0, SZ_D, slot_addr(top_q, nslots_q, slot_nx), '0};
              end
            end
          end
        end
        ST_A0: wb_q <= '{1'b1, REG_A0, '0}; // RL15
        ST_SP: begin
          wb_q <= '{1'b1, REG_SP, is_push ? sp_q - adj_q : sp_q + adj_q}; // RL19
          done_q <= !is_ret;
        end
        ST_RET: begin
          jmp_q <= '{1'b1, ret_q}; // RL16
          done_q <= 1'b1;
        end
        default: mem_q.valid <= 1'b0;
      endcase
    end
  end

  // outputs straight from flops
  assign O_RF_RADDR = raddr_q;
  assign O_MEM = mem_q;
  assign O_WB = wb_q;
  assign O_JUMP = jmp_q;
  assign O_BUSY = busy_q;
  assign O_DONE = done_q;
  assign O_FAULT = fault_q;
  assign O_ILLEGAL = illegal_q;

  // checks on the result paths
  sequence s_sp_released;
    O_WB.valid && O_WB.idx == REG_SP && !O_JUMP.valid;
  endsequence
  sequence s_return;
    O_JUMP.valid && O_JUMP.target == ret_q && !O_WB.valid;
  endsequence

  a_creg_window: assert property (@(posedge I_CLK) disable iff (I_RST) // RL4
    go_alu |=> O_WB.valid && O_WB.idx[4:3] == CREG_HI)
    else $error("compact register outside x8..x15");
  a_zext_byte: assert property (@(posedge I_CLK) disable iff (I_RST) // RL5
    (go_alu && dec_un && uop == U_ZEXT_B)
    |=> O_WB.data == XLEN'($past(I_ISSUE.rsd_val[7:0])))
    else $error("byte zero-extend result wrong");
  a_sext_byte: assert property (@(posedge I_CLK) disable iff (I_RST) // RL6
    (go_alu && dec_un && uop == U_SEXT_B)
    |=> O_WB.data[XLEN-1:8] == {(XLEN-8){$past(I_ISSUE.rsd_val[7])}})
    else $error("byte sign-extend high bits wrong");
  a_not_result: assert property (@(posedge I_CLK) disable iff (I_RST) // RL10
    (go_alu && dec_un && uop == U_NOT) |=> O_WB.data == ~$past(I_ISSUE.rsd_val))
    else $error("complement result wrong");
  a_mul_low: assert property (@(posedge I_CLK) disable iff (I_RST) // RL11
    (go_alu && dec_mul)
    |=> O_WB.data == XLEN'($past(I_ISSUE.rsd_val) * $past(I_ISSUE.rs2_val)))
    else $error("multiply low half wrong");
  a_mul_gated: assert property (@(posedge I_CLK) disable iff (I_RST) // RL12
    (take && dec_mul && !mul_ok) |=> O_ILLEGAL && !O_WB.valid)
    else $error("multiply ran without extension");
  a_sb_request: assert property (@(posedge I_CLK) disable iff (I_RST) // RL17
    (take && dec_sb) |=> O_MEM.valid && O_MEM.write && O_MEM.size == SZ_B
      && O_MEM.addr == $past(I_ISSUE.rsd_val) + XLEN'({$past(ins[5]), $past(ins[6])}))
    else $error("byte store request wrong");
  a_push_fault: assert property (@(posedge I_CLK) disable iff (I_RST) // RL19
    (resp_err && frame_q) |=> O_FAULT && !O_WB.valid ##1 !O_WB.valid)
    else $error("stack pointer touched after fault");
  a_popretz_a0: assert property (@(posedge I_CLK) disable iff (I_RST) // RL15
    (state_q == ST_SP && op_q == FR_POPRETZ)
    |-> O_WB.valid && O_WB.idx == REG_A0 && O_WB.data == '0)
    else $error("a0 not zeroed before release");
  a_ret_order: assert property (@(posedge I_CLK) disable iff (I_RST) // RL16
    (state_q == ST_RET) |-> s_sp_released ##1 s_return)
    else $error("return not after frame release");

endmodule

// file: cbops_pkg.sv
/*
  Shared constants and carrier types for the compressed byte/halfword
  operation and stack frame push/pop execution block.
  Assumes a 64-bit integer core with the compressed base present.
*/
package cbops_pkg;

  // datapath geometry
  localparam int XLEN = 64;
  localparam int RIDX = 5;

  // quadrant and major function codes
  localparam logic [1:0] OP_Q0 = 2'h0;
  localparam logic [1:0] OP_Q1 = 2'h1;
  localparam logic [1:0] OP_Q2 = 2'h2;
  localparam logic [5:0] F6_STORE_B = 6'h22;
  localparam logic [5:0] F6_STORE_H = 6'h23;
  localparam logic [5:0] F6_UNARY = 6'h27;
  localparam logic [1:0] SEL_UNARY = 2'h3;
  localparam logic [1:0] SEL_MUL = 2'h2;
  localparam logic [2:0] F3_FRAME = 3'h5;

  // unary sub-operations
  localparam logic [2:0] U_ZEXT_B = 3'h0;
  localparam logic [2:0] U_SEXT_B = 3'h1;
  localparam logic [2:0] U_ZEXT_H = 3'h2;
  localparam logic [2:0] U_SEXT_H = 3'h3;
  localparam logic [2:0] U_ZEXT_W = 3'h4;
  localparam logic [2:0] U_NOT = 3'h5;

  // frame instruction selectors (bits 12..8)
  localparam logic [4:0] PP_PUSH = 5'h18;
  localparam logic [4:0] PP_POP = 5'h1A;
  localparam logic [4:0] PP_POPRETZ = 5'h1C;
  localparam logic [4:0] PP_POPRET = 5'h1E;

  // register list limits and register numbers
  localparam logic [3:0] RLIST_MIN = 4'h4;
  localparam logic [3:0] RLIST_ALL = 4'hF;
  localparam logic [3:0] NSLOT_ALL = 4'hD;
  localparam logic [3:0] RLIST_BIAS = 4'h3;
  localparam logic [1:0] CREG_HI = 2'h1;
  localparam logic [4:0] REG_RA = 5'h01;
  localparam logic [4:0] REG_SP = 5'h02;
  localparam logic [4:0] REG_S0 = 5'h08;
  localparam logic [4:0] REG_S1 = 5'h09;
  localparam logic [4:0] REG_A0 = 5'h0A;
  localparam logic [4:0] SLOT_S2_BIAS = 5'h0F;

  // access sizes and frame arithmetic
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_D = 2'h3;
  localparam int SLOT_SHIFT = 3;
  localparam int ADJ_SHIFT = 4;

  typedef enum logic [1:0] {FR_PUSH, FR_POP, FR_POPRET, FR_POPRETZ} frame_op_t;
  typedef enum {ST_IDLE, ST_RD, ST_REQ, ST_RESP, ST_A0, ST_SP, ST_RET} state_t;

  typedef struct packed {
    logic valid;
    logic [15:0] instr;
    logic [XLEN-1:0] rsd_val;
    logic [XLEN-1:0] rs2_val;
    logic [XLEN-1:0] sp_val;
  } issue_t;

  typedef struct packed {
    logic has_m;
    logic has_zmmul;
    logic has_zbb;
    logic has_zba;
  } cfg_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic [XLEN-1:0] addr;
    logic [XLEN-1:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [XLEN-1:0] rdata;
  } mem_resp_t;

  typedef struct packed {
    logic valid;
    logic [RIDX-1:0] idx;
    logic [XLEN-1:0] data;
  } wb_t;

  typedef struct packed {
    logic valid;
    logic [XLEN-1:0] target;
  } jump_t;

endpackage

// file: cbops_mem_model.sv
/*
  Partner model: register file read port and a memory unit with one access in flight.
  Assumes the block holds each request until ready; the bench reads the store log.
*/
module cbops_mem_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register file
  input wire logic [4:0] i_rf_raddr,
  output logic [63:0] o_rf_rdata,
  // memory port
  input cbops_pkg::mem_req_t i_mem,
  output logic o_mem_ready,
  output cbops_pkg::mem_resp_t o_mem_resp,
  // stall and error control
  input wire logic i_slow,
  input wire logic [15:0] i_err_at
);
  timeunit 1ns;
  timeprecision 1ps;
  import cbops_pkg::*;
  logic [63:0] st_addr[$];
  logic [63:0] st_data[$];
  logic [1:0] st_size[$];
  logic [15:0] n_req;
  logic [1:0] wait_q;
  logic pend_q;
  logic err_q;
  logic [63:0] rd_q;

  // fixed contents per register number, so the bench can predict them
  assign o_rf_rdata = 64'h0123_4567_89AB_CD00 | 64'(i_rf_raddr);

  // optional stall before ready and before the response
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_ready <= 1'b0;
      o_mem_resp <= '0;
      n_req <= 16'h0000;
      wait_q <= 2'h0;
      pend_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= 64'h0;
    end else begin
      o_mem_resp.valid <= 1'b0;
      o_mem_resp.err <= ~o_mem_resp.err; // released lines never hold a value
      o_mem_resp.rdata <= ~o_mem_resp.rdata;
      o_mem_ready <= 1'b0;
      if (i_mem.valid && o_mem_ready) begin
        n_req <= n_req + 16'h0001;
        pend_q <= 1'b1;
        wait_q <= i_slow ? 2'h3 : 2'h0;
        err_q <= (n_req == i_err_at);
        rd_q <= ~i_mem.addr;
        if (i_mem.write) begin
          st_addr.push_back(i_mem.addr);
          st_data.push_back(i_mem.wdata);
          st_size.push_back(i_mem.size);
        end
      end else if (pend_q) begin
        if (wait_q != 2'h0) begin
          wait_q <= wait_q - 2'h1;
        end else begin
          pend_q <= 1'b0;
          o_mem_resp <= {1'b1, err_q, rd_q};
        end
      end else if (i_mem.valid) begin
        if (wait_q == (i_slow ? 2'h2 : 2'h0)) o_mem_ready <= 1'b1;
        else wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// file: compressed_byte_ops_and_stack_frame_tb.sv
/*
  Self-checking bench for the compressed ops and stack frame block.
  Assumes the partner model answers register reads and memory accesses.
*/
module compressed_byte_ops_and_stack_frame_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbops_pkg::*;
  logic clk, rst, slow, iss_req, iss_first;
  logic [15:0] iss_instr, err_at;
  logic [63:0] iss_rsd, iss_rs2, iss_sp, rf_rdata;
  logic [4:0] rf_raddr;
  logic ready, busy, done, fault, illegal;
  issue_t iss;
  cfg_t cfg;
  mem_req_t mreq;
  mem_resp_t mresp;
  wb_t wb;
  jump_t jump;
  int bad_count, cmp_count;
  wb_t wbq[$];
  wb_t ewb[$];
  logic [63:0] jq[$];
  localparam logic [63:0] RF_BASE = 64'h0123_4567_89AB_CD00;

  // valid drops with busy, so a finished sequence is never offered again
  assign iss = {iss_req && (iss_first || busy), iss_instr, iss_rsd, iss_rs2, iss_sp};

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  compressed_byte_ops_and_stack_frame DUT (.I_CLK(clk), .I_RST(rst), .I_ISSUE(iss),
    .I_CFG(cfg), .O_RF_RADDR(rf_raddr), .I_RF_RDATA(rf_rdata), .O_MEM(mreq),
    .I_MEM_READY(ready), .I_MEM_RESP(mresp), .O_WB(wb), .O_JUMP(jump), .O_BUSY(busy),
    .O_DONE(done), .O_FAULT(fault), .O_ILLEGAL(illegal));

  cbops_mem_model model (.i_clk(clk), .i_rst(rst), .i_rf_raddr(rf_raddr),
    .o_rf_rdata(rf_rdata), .i_mem(mreq), .o_mem_ready(ready), .o_mem_resp(mresp),
    .i_slow(slow), .i_err_at(err_at));

  // one-cycle pulses are logged mid-cycle where they are settled
  always @(negedge clk) begin
    if (wb.valid === 1'b1) wbq.push_back(wb);
    if (jump.valid === 1'b1) jq.push_back(jump.target);
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [15:0] enc_u(input logic [2:0] r, input logic [2:0] op);
    return {F6_UNARY, r, SEL_UNARY, op, OP_Q1};
  endfunction

  function automatic logic [15:0] enc_fr(input logic [4:0] pp, input logic [3:0] rl,
                                         input logic [1:0] si);
    return {F3_FRAME, pp, rl, si, OP_Q2};
  endfunction

  function automatic logic [4:0] slot_reg(input int k);
    return (k == 0) ? 5'h01 : (k == 1) ? 5'h08 : (k == 2) ? 5'h09 : 5'(k + 15);
  endfunction

  function automatic logic [63:0] unary(input logic [2:0] op, input logic [63:0] a);
    case (op)
      U_ZEXT_B: return {56'h0, a[7:0]};
      U_SEXT_B: return {{56{a[7]}}, a[7:0]};
      U_ZEXT_H: return {48'h0, a[15:0]};
      U_SEXT_H: return {{48{a[15]}}, a[15:0]};
      U_ZEXT_W: return {32'h0, a[31:0]};
      default: return ~a;
    endcase
  endfunction

  // offer one instruction and wait for its completion, fault or refusal
  task automatic run(input logic [15:0] ins, input logic [63:0] a, b, s, output logic f, il);
    int n;
    wbq.delete();
    jq.delete();
    ewb.delete();
    @(posedge clk);
    iss_instr <= ins;
    iss_rsd <= a;
    iss_rs2 <= b;
    iss_sp <= s;
    iss_req <= 1'b1;
    iss_first <= 1'b1;
    @(posedge clk);
    iss_first <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((done | fault | illegal) !== 1'b1 && n < 400);
    chk("completion", 64'(n < 400), 64'h1);
    f = fault;
    il = illegal;
    @(posedge clk);
    iss_req <= 1'b0;
  endtask

  task automatic chk_wb();
    chk("wb count", 64'(wbq.size()), 64'(ewb.size()));
    foreach (ewb[i]) begin
      if (i < wbq.size()) begin
        chk("wb idx", 64'(wbq[i].idx), 64'(ewb[i].idx));
        chk("wb data", wbq[i].data, ewb[i].data);
      end
    end
  endtask

  task automatic t_alu();
    logic [63:0] v[2];
    logic f, il;
    v = '{64'h1234_5678_9ABC_DEF0, 64'hFEDC_BA98_7654_3270};
    for (int k = 0; k < 2; k++) begin
      for (int op = 0; op < 6; op++) begin
        run(enc_u(3'(op + 2), 3'(op)), v[k], 64'h0, 64'h0, f, il);
        ewb.push_back('{1'b1, 5'(op + 10), unary(3'(op), v[k])});
        chk_wb();
      end
      run({F6_UNARY, 3'h7, SEL_MUL, 3'h1, OP_Q1}, v[k], 64'hFFFF_FFFF_FFFF_FFFD, 0, f, il);
      ewb.push_back('{1'b1, 5'h0F, v[k] * 64'hFFFF_FFFF_FFFF_FFFD});
      chk_wb();
    end
  endtask

  task automatic t_gate();
    cfg_t c[10];
    logic [15:0] ins[10];
    logic e[10];
    logic f, il;
    c = '{4'hD, 4'hD, 4'hD, 4'h0, 4'h0, 4'hE, 4'h3, 4'h4, 4'hF, 4'hF};
    ins = '{enc_u(0, U_SEXT_B), enc_u(1, U_ZEXT_H), enc_u(2, U_SEXT_H), enc_u(3, U_ZEXT_B),
            enc_u(4, U_NOT), enc_u(5, U_ZEXT_W), {F6_UNARY, 3'h0, SEL_MUL, 3'h1, OP_Q1},
            {F6_UNARY, 3'h0, SEL_MUL, 3'h1, OP_Q1}, enc_u(6, 3'h6), enc_fr(PP_PUSH, 4'h3, 0)};
    e = '{1, 1, 1, 0, 0, 1, 1, 0, 1, 1};
    for (int i = 0; i < 10; i++) begin
      cfg <= c[i];
      run(ins[i], 64'h0000_0000_8000_8080, 64'h3, 64'h0, f, il);
      chk("illegal", 64'(il), 64'(e[i]));
      chk("wb count", 64'(wbq.size()), 64'(!e[i]));
    end
    cfg <= 4'hF;
  endtask

  task automatic t_store();
    logic [15:0] ins[3];
    logic [63:0] base, d;
    logic f, il;
    ins = '{{F6_STORE_B, 3'h1, 2'b10, 3'h2, OP_Q0}, {F6_STORE_B, 3'h1, 2'b01, 3'h2, OP_Q0},
            {F6_STORE_H, 3'h1, 2'b01, 3'h2, OP_Q0}};
    base = 64'h0000_0000_0000_1FFF;
    d = 64'hA5A5_5A5A_C3C3_9696;
    for (int i = 0; i < 3; i++) begin
      slow <= (i == 2);
      run(ins[i], base, d, 64'h0, f, il);
      chk("store addr", model.st_addr[$], base + ((i == 0) ? 64'h1 : 64'h2));
      chk("store size", 64'(model.st_size[$]), 64'((i == 2) ? SZ_H : SZ_B));
      chk("store data", model.st_data[$], (i == 2) ? {48'h0, d[15:0]} : {56'h0, d[7:0]});
    end
  endtask

  task automatic t_push(input logic [3:0] rl, input logic [1:0] si, input logic sl, input int nf);
    int n, s0;
    logic f, il;
    logic [63:0] sp;
    sp = 64'h0000_0000_0001_0000;
    n = (rl == 4'hF) ? 13 : int'(rl) - 3;
    s0 = model.st_addr.size();
    slow <= sl;
    err_at <= (nf < 0) ? 16'hFFFF : model.n_req + 16'(nf);
    run(enc_fr(PP_PUSH, rl, si), 64'h0, 64'h0, sp, f, il);
    chk("push fault", 64'(f), 64'(nf >= 0));
    chk("store count", 64'(model.st_addr.size() - s0), 64'((nf < 0) ? n : nf + 1));
    for (int k = 0; k < n && s0 + k < model.st_addr.size(); k++) begin
      chk("store addr", model.st_addr[s0 + k], sp - 64'((n - k) * 8));
      chk("store data", model.st_data[s0 + k], RF_BASE | 64'(slot_reg(k)));
    end
    if (nf < 0) ewb.push_back('{1'b1, REG_SP, sp - 64'(((n + 1) / 2 + si) * 16)});
    chk_wb();
  endtask

  task automatic t_pop(input logic [4:0] pp, input logic [3:0] rl, input logic [1:0] si,
                       input int nf);
    int n;
    logic f, il;
    logic [63:0] sp, top;
    sp = 64'h0000_0000_0002_0000;
    n = (rl == 4'hF) ? 13 : int'(rl) - 3;
    top = sp + 64'(((n + 1) / 2 + si) * 16);
    err_at <= (nf < 0) ? 16'hFFFF : model.n_req + 16'(nf);
    run(enc_fr(pp, rl, si), 64'h0, 64'h0, sp, f, il);
    chk("pop fault", 64'(f), 64'(nf >= 0));
    for (int k = 0; k < n && (nf < 0 || k < nf); k++) begin
      ewb.push_back('{1'b1, slot_reg(k), ~(top - 64'((n - k) * 8))});
    end
    if (nf < 0 && pp == PP_POPRETZ) ewb.push_back('{1'b1, REG_A0, 64'h0});
    if (nf < 0) ewb.push_back('{1'b1, REG_SP, top});
    chk_wb();
    chk("jump count", 64'(jq.size()), 64'(nf < 0 && pp != PP_POP));
    if (jq.size() > 0) chk("jump target", jq[0], ~(top - 64'(n * 8)));
  endtask

  initial begin
    rst = 1'b1;
    slow = 1'b0;
    iss_req = 1'b0;
    iss_first = 1'b0;
    iss_instr = 16'h0000;
    iss_rsd = 64'h0;
    iss_rs2 = 64'h0;
    iss_sp = 64'h0;
    cfg = 4'hF;
    err_at = 16'hFFFF;
    bad_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_alu();
    t_gate();
    t_store();
    t_push(4'h5, 2'h1, 1'b0, -1);
    t_push(4'hF, 2'h0, 1'b1, -1);
    t_push(4'h6, 2'h0, 1'b0, 1);
    t_pop(PP_POPRETZ, 4'h5, 2'h0, -1);
    t_pop(PP_POPRET, 4'h4, 2'h2, -1);
    t_pop(PP_POP, 4'h8, 2'h1, -1);
    t_pop(PP_POPRETZ, 4'h7, 2'h0, 2);
    print_verdict();
  end

  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    #60000;
    bad_count++;
    print_verdict();
  end
endmodule
